// ==== pot_spi_pkg.sv ====
// Shared constants for the dual potentiometer serial link
package pot_spi_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;          // System clock period
  localparam int SCK_PERIOD_NS = 800;          // Serial clock period made by the host
  localparam int LEAD_TIME_NS = 250;           // Select low to first clock edge
  localparam int LAG_TIME_NS = 250;            // Last clock edge to select high
  localparam int DESELECT_TIME_NS = 2000;      // Least select high time
  localparam int NV_WRITE_TIME_NS = 20000000;  // Longest non-volatile write
  localparam logic [4:0] SCK_HALF_CYCLES = 5'(SCK_PERIOD_NS / 2 / CLK_PERIOD_NS);
  localparam logic [4:0] LEAD_CYCLES = 5'((LEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] LAG_CYCLES = 5'((LAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] DESELECT_CYCLES = 5'((DESELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [2:0] BOOT_CYCLES = 3'h4;   // Cycles before stored values are trusted

  // ****************************************
  // Protocol
  // ****************************************
  localparam logic [3:0] DEVICE_CODE = 4'ha;   // Arbitrary value
  localparam logic [3:0] INSTR_READ = 4'hb;
  localparam logic [3:0] INSTR_WRITE = 4'hc;
  localparam logic [4:0] DATA_FIRST_BIT = 5'h10; // First bit of the data byte
  localparam logic [4:0] LAST_BIT = 5'h17;       // Last of 24 bits

  // ****************************************
  // Device register map
  // ****************************************
  localparam logic [3:0] ADDR_POT0 = 4'h0;
  localparam logic [3:0] ADDR_POT1 = 4'h1;
  localparam logic [3:0] ADDR_LAST_NV = 4'h6;
  localparam logic [3:0] ADDR_ACCESS_CONTROL = 4'h8;
  localparam int NV_COUNT = 7;
  localparam int CTRL_VOLATILE_BIT = 7;
  localparam int CTRL_SHUTDOWN_BIT = 6;
  localparam int CTRL_PENDING_BIT = 5;
  localparam logic [7:0] WIPER_RESET = 8'h40;
  localparam logic [7:0] NV_RESET = 8'h00;

  // ****************************************
  // Host command registers
  // ****************************************
  localparam logic [1:0] HOST_CMD = 2'h0;      // [7] start, [4] read, [3:0] address
  localparam logic [1:0] HOST_TXDATA = 2'h1;
  localparam logic [1:0] HOST_RXDATA = 2'h2;
  localparam logic [1:0] HOST_STATUS = 2'h3;   // [0] busy
  localparam int CMD_START_BIT = 7;
  localparam int CMD_READ_BIT = 4;

endpackage : pot_spi_pkg

// ==== spi_link_if.sv ====
// Serial link between host and potentiometer device
`timescale 1ns/100ps
interface spi_link_if;
  logic cs_n;       // Chip select, low active
  logic sck;        // Serial clock from host
  logic sdi;        // Data host to device
  logic sdo_drive;  // Device output value
  logic sdo_oe_n;   // Device pulls line while low
  logic sdo_line;   // Resolved open-drain line

  // Pull-up: released line reads high
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo_drive;

  modport device (input cs_n, input sck, input sdi, output sdo_drive, output sdo_oe_n);
  modport host (output cs_n, output sck, output sdi, input sdo_line);
endinterface : spi_link_if

// ==== pot_spi_device.sv ====
// Device end: serial register slave and wiper control
//
// Behaviour
// R01: Wiper code 00h low end, 7Fh high.
// R02: Wipers start 40h, then load stored values.
// R03: Shutdown pin low or control bit six.
// R04: Link works in shutdown; wipers restored after.
// R05: Open-drain output changes on falling clock.
// R06: Sample input on rising clock, select low.
// R07: Host falls select before any transfer.
// R08: Select high means idle unless writing.
// R09: Mode 0, host master, MSB first.
// R10: First byte is device code, low nibble zero.
// R11: Second byte: instruction and register address.
// R12: Host write: code, instruction, data, deselect.
// R13: Volatile bit picks wiper-only or both.
// R14: Write address advances, six wraps to zero.
// R15: Stored write starts at deselect, 20 ms.
// R16: Pending bit blocks wiper, stored, control writes; code still accepts spare stored writes at 2-6.
// R17: Volatile bit at seven, defaults zero.
// R18: Shared pot addresses, spare stored at 2-6.
// R19: Host read: code, instruction, dummy byte.
// R20: Read pointer advances, six wraps to zero.
// R21: Host checks pending bit before stored reads.
// R22: Control register at address eight.
// R23: Bad code or instruction: ignore until deselect.
`timescale 1ns/100ps
module pot_spi_device
  #(
  parameter int unsigned NV_WRITE_CYCLES = pot_spi_pkg::NV_WRITE_CYCLES
  )
  (
  input wire logic clk_i,
  input wire logic reset_n_i,
  spi_link_if.device link,
  input wire logic shutdown_n_i,
  output logic [6:0] wiper0_tap_o,
  output logic [6:0] wiper1_tap_o,
  output logic high_open_o,
  output logic nv_write_pending_o
  );
  import pot_spi_pkg::*;

  // ****************************************
  // State
  // ****************************************
  localparam int CNT_W = $clog2(NV_WRITE_CYCLES + 1);

  typedef enum logic [2:0] {IDLE, ID_BYTE, INSTR_BYTE, WRITE_DATA, READ_DATA, IGNORE} link_state_type;

  typedef struct packed {
    logic cs_meta;                     // Synchroniser first stages
    logic cs_sync;
    logic cs_prev;
    logic sck_meta;
    logic sck_sync;
    logic sck_prev;
    logic sdi_meta;
    logic sdi_sync;
    logic pin_meta;
    logic pin_sync;
    link_state_type state;
    logic [2:0] bit_cnt;               // Bits of current byte
    logic [7:0] rx;                    // Incoming shift
    logic [7:0] tx;                    // Outgoing shift
    logic [3:0] ptr;                   // Register pointer
    logic sdo_low;                     // Pulling output low
    logic [1:0][7:0] wiper;            // Volatile wiper codes
    logic [NV_COUNT-1:0][7:0] nv;      // Stored values, index = address
    logic volatile_sel;                // Volatile-only select
    logic soft_shutdown;               // Software shutdown request
    logic nv_dirty;                    // Stored write seen this frame
    logic [CNT_W-1:0] pending_cnt;     // Non-zero while stored write runs
    logic [2:0] boot_cnt;
    logic booted;
    logic [1:0][6:0] tap;              // Applied wiper taps
    logic high_open;                   // High terminal opened
  } dev_state_type;

  dev_state_type r;
  dev_state_type next_r;

  // Register read mux
  function automatic logic [7:0] read_reg(input dev_state_type s, input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a <= ADDR_POT1)
    begin
      v = s.volatile_sel ? s.wiper[a[0]] : s.nv[a[0]];
    end
    else if (a <= ADDR_LAST_NV)
    begin
      v = s.nv[a[2:0]];  // [R18]
    end
    else if (a == ADDR_ACCESS_CONTROL)
    begin
      v[CTRL_VOLATILE_BIT] = s.volatile_sel;
      v[CTRL_SHUTDOWN_BIT] = s.soft_shutdown;
      v[CTRL_PENDING_BIT] = (s.pending_cnt != '0);  // [R16]
    end
    return v;
  endfunction : read_reg

  // Pointer advance with rollover
  function automatic logic [3:0] next_ptr(input logic [3:0] p);
    return (p == ADDR_LAST_NV) ? ADDR_POT0 : 4'(p + 4'h1);  // [R14] [R20]
  endfunction : next_ptr

  // ****************************************
  // Next state
  // ****************************************
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic byte_done;
  logic pending;
  logic shutdown;
  logic [7:0] rx_byte;

  // Whole-block combinational update
  always_comb
  begin
    next_r = r;
    // Two-flop synchronisers plus edge history
    next_r.cs_meta = link.cs_n;
    next_r.cs_sync = r.cs_meta;
    next_r.cs_prev = r.cs_sync;
    next_r.sck_meta = link.sck;
    next_r.sck_sync = r.sck_meta;
    next_r.sck_prev = r.sck_sync;
    next_r.sdi_meta = link.sdi;
    next_r.sdi_sync = r.sdi_meta;
    next_r.pin_meta = shutdown_n_i;
    next_r.pin_sync = r.pin_meta;

    sck_rise = r.sck_sync & ~r.sck_prev & ~r.cs_sync;  // [R06]
    sck_fall = ~r.sck_sync & r.sck_prev & ~r.cs_sync;  // [R05]
    cs_rise = r.cs_sync & ~r.cs_prev;
    cs_fall = ~r.cs_sync & r.cs_prev;
    rx_byte = {r.rx[6:0], r.sdi_sync};  // [R09]
    byte_done = sck_rise & (r.bit_cnt == 3'h7);
    pending = (r.pending_cnt != '0);

    // Stored write timer
    if (pending)
    begin
      next_r.pending_cnt = r.pending_cnt - 1'b1;
    end

    // Power-up recall after settling time
    if (!r.booted)
    begin
      next_r.boot_cnt = r.boot_cnt + 3'h1;
      if (r.boot_cnt == BOOT_CYCLES - 3'h1)
      begin
        next_r.booted = 1'b1;
        next_r.wiper[0] = r.nv[0];  // [R02]
        next_r.wiper[1] = r.nv[1];  // [R02]
      end
    end

    // Shift in on every sampled rising edge of a frame
    if (sck_rise && r.state != IDLE)
    begin
      next_r.rx = rx_byte;
      next_r.bit_cnt = r.bit_cnt + 3'h1;
    end

    unique case (r.state)
      // Standby: wait for a select fall
      IDLE:
      begin
        if (cs_fall && r.booted)  // [R07]
        begin
          next_r.state = ID_BYTE;
          next_r.bit_cnt = 3'h0;
        end
      end
      // Device code check
      ID_BYTE:
      begin
        if (byte_done)
        begin
          next_r.state = (rx_byte == {DEVICE_CODE, 4'h0}) ? INSTR_BYTE : IGNORE;  // [R10] [R23]
        end
      end
      // Instruction and address
      INSTR_BYTE:
      begin
        if (byte_done)
        begin
          next_r.ptr = rx_byte[3:0];  // [R11]
          if (rx_byte[7:4] == INSTR_READ)
          begin
            next_r.state = READ_DATA;
            next_r.tx = read_reg(r, rx_byte[3:0]);
          end
          else if (rx_byte[7:4] == INSTR_WRITE)
          begin
            next_r.state = WRITE_DATA;
          end
          else
          begin
            next_r.state = IGNORE;  // [R23]
          end
        end
      end
      // Data bytes into registers
      WRITE_DATA:
      begin
        if (byte_done)
        begin
          if (r.ptr <= ADDR_POT1)
          begin
            // Pending stored write locks the wipers out
            if (!pending)  // [R16]
            begin
              next_r.wiper[r.ptr[0]] = rx_byte;  // [R13]
              if (!r.volatile_sel)  // [R17]
              begin
                next_r.nv[r.ptr[0]] = rx_byte;  // [R13]
                next_r.nv_dirty = 1'b1;
              end
            end
          end
          else if (r.ptr <= ADDR_LAST_NV)
          begin
            next_r.nv[r.ptr[2:0]] = rx_byte;  // [R18]
            next_r.nv_dirty = 1'b1;
          end
          else if (r.ptr == ADDR_ACCESS_CONTROL && !pending)  // [R22] [R16]
          begin
            next_r.volatile_sel = rx_byte[CTRL_VOLATILE_BIT];  // [R17]
            next_r.soft_shutdown = rx_byte[CTRL_SHUTDOWN_BIT];  // [R03]
          end
          next_r.ptr = next_ptr(r.ptr);  // [R14]
        end
      end
      // Data bytes out while clocked
      READ_DATA:
      begin
        if (byte_done)
        begin
          next_r.ptr = next_ptr(r.ptr);  // [R20]
          next_r.tx = read_reg(r, next_ptr(r.ptr));
        end
        else if (sck_fall)
        begin
          next_r.sdo_low = ~r.tx[7];  // [R05] [R09]
          next_r.tx = {r.tx[6:0], 1'b0};
        end
      end
      // Bad frame: wait for deselect
      IGNORE:
      begin
        next_r.sdo_low = 1'b0;  // [R23]
      end
    endcase

    // Deselect ends the frame and may start the stored write
    if (r.cs_sync)  // [R08]
    begin
      next_r.state = IDLE;
      next_r.sdo_low = 1'b0;  // [R05]
    end
    if (cs_rise && next_r.nv_dirty)  // [R15]
    begin
      next_r.pending_cnt = CNT_W'(NV_WRITE_CYCLES);
      next_r.nv_dirty = 1'b0;
    end

    // Shutdown parks taps low; wiper codes stay intact
    shutdown = ~r.pin_sync | r.soft_shutdown;  // [R03]
    next_r.high_open = shutdown;  // [R03]
    for (int i = 0; i < 2; i++)
    begin
      next_r.tap[i] = shutdown ? 7'h00 : r.wiper[i][6:0];  // [R01] [R04]
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // State register, async reset to constants
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      r <= '0;
      r.cs_meta <= 1'b1;
      r.cs_sync <= 1'b1;
      r.cs_prev <= 1'b1;
      r.pin_meta <= 1'b1;
      r.pin_sync <= 1'b1;
      r.state <= IDLE;
      r.wiper <= {2{WIPER_RESET}};  // [R02]
      r.nv <= {NV_COUNT{NV_RESET}};
      r.tap <= {2{WIPER_RESET[6:0]}};
    end
    else
    begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.sdo_drive = 1'b0;          // Open drain only pulls low
  assign link.sdo_oe_n = ~r.sdo_low;     // [R05]
  assign wiper0_tap_o = r.tap[0];
  assign wiper1_tap_o = r.tap[1];
  assign high_open_o = r.high_open;
  assign nv_write_pending_o = (r.pending_cnt != '0);
endmodule : pot_spi_device

// ==== pot_spi_host.sv ====
// Host end: register-driven serial master for the device
`timescale 1ns/100ps
module pot_spi_host
  (
  input wire logic clk_i,
  input wire logic reset_n_i,
  spi_link_if.host link,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o
  );
  import pot_spi_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {IDLE, LEAD, CLK_LOW, CLK_HIGH, LAG, GAP} host_state_type;

  typedef struct packed {
    host_state_type state;
    logic [4:0] cnt;        // Phase timer
    logic [4:0] bit_idx;    // Bit of the 24-bit frame
    logic [23:0] shift;     // Outgoing frame
    logic is_read;
    logic [7:0] txdata;     // Data byte to send
    logic [7:0] rxdata;     // Last byte read
    logic [7:0] rdata;      // Bus read answer
    logic cs_n;
    logic sck;
    logic sdi;
    logic sdo_meta;
    logic sdo_sync;
  } host_reg_type;

  host_reg_type r;
  host_reg_type next_r;

  // ****************************************
  // Next state
  // ****************************************
  // Command port and frame sequencer
  always_comb
  begin
    next_r = r;
    next_r.sdo_meta = link.sdo_line;
    next_r.sdo_sync = r.sdo_meta;
    next_r.rdata = 8'h00;  // Read data stand one cycle only
    next_r.cnt = (r.cnt != 5'h0) ? r.cnt - 5'h1 : 5'h0;

    // Register reads
    if (rd_i)
    begin
      unique case (addr_i)
        HOST_CMD: next_r.rdata = 8'h00;
        HOST_TXDATA: next_r.rdata = r.txdata;
        HOST_RXDATA: next_r.rdata = r.rxdata;
        HOST_STATUS: next_r.rdata = {7'h00, r.state != IDLE};
      endcase
    end
    if (wr_i && addr_i == HOST_TXDATA)
    begin
      next_r.txdata = wdata_i;
    end

    unique case (r.state)
      // Start only from idle; busy starts are dropped
      IDLE:
      begin
        if (wr_i && addr_i == HOST_CMD && wdata_i[CMD_START_BIT])
        begin
          next_r.state = LEAD;
          next_r.cs_n = 1'b0;  // [R07] [R12] [R19]
          next_r.is_read = wdata_i[CMD_READ_BIT];
          next_r.shift = {DEVICE_CODE, 4'h0,
                          wdata_i[CMD_READ_BIT] ? INSTR_READ : INSTR_WRITE,
                          wdata_i[3:0], r.txdata};  // [R10] [R11]
          next_r.sdi = DEVICE_CODE[3];
          next_r.cnt = LEAD_CYCLES;
          next_r.bit_idx = 5'h0;
        end
      end
      // Select set-up before first edge
      LEAD:
      begin
        if (r.cnt == 5'h0)
        begin
          next_r.state = CLK_LOW;
          next_r.cnt = SCK_HALF_CYCLES - 5'h1;
        end
      end
      // Clock low half: data stands for the rising edge
      CLK_LOW:
      begin
        if (r.cnt == 5'h0)
        begin
          next_r.state = CLK_HIGH;
          next_r.sck = 1'b1;  // [R09]
          next_r.cnt = SCK_HALF_CYCLES - 5'h1;
        end
      end
      // Clock high half: capture before the fall
      CLK_HIGH:
      begin
        if (r.cnt == 5'h0)
        begin
          if (r.is_read && r.bit_idx >= DATA_FIRST_BIT)
          begin
            next_r.rxdata = {r.rxdata[6:0], r.sdo_sync};  // [R19]
          end
          next_r.sck = 1'b0;
          next_r.shift = {r.shift[22:0], 1'b0};
          next_r.sdi = r.shift[22];  // [R09]
          next_r.bit_idx = r.bit_idx + 5'h1;
          next_r.cnt = (r.bit_idx == LAST_BIT) ? LAG_CYCLES : SCK_HALF_CYCLES - 5'h1;
          next_r.state = (r.bit_idx == LAST_BIT) ? LAG : CLK_LOW;
        end
      end
      // Hold select after last edge, then release
      LAG:
      begin
        if (r.cnt == 5'h0)
        begin
          next_r.cs_n = 1'b1;  // [R12] [R15]
          next_r.sdi = 1'b0;
          next_r.state = GAP;
          next_r.cnt = DESELECT_CYCLES;
        end
      end
      // Least deselect time between frames
      GAP:
      begin
        if (r.cnt == 5'h0)
        begin
          next_r.state = IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  // Async reset to an idle, deselected link
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      r <= '0;
      r.state <= IDLE;
      r.cs_n <= 1'b1;
      r.sdo_meta <= 1'b1;
      r.sdo_sync <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign link.cs_n = r.cs_n;
  assign link.sck = r.sck;
  assign link.sdi = r.sdi;
  assign rdata_o = r.rdata;
endmodule : pot_spi_host

// ==== pot_spi_monitor.sv ====
// Checker for the wire between host end and device end
`timescale 1ns/100ps
module pot_spi_monitor
  (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_drive,
  input wire logic sdo_oe_n,
  input wire logic sdo_line
  );
  // ****************************************
  // Frame bit counter
  // ****************************************
  typedef struct packed {
    logic sck_q;        // Serial clock one cycle back
    logic [4:0] rises;  // Serial clock rises in this frame
  } mon_state_type;
  mon_state_type state;
  mon_state_type next_state;

  // Count rises while selected; lags the wire by one cycle
  always_comb
  begin
    next_state = state;
    next_state.sck_q = sck;
    if (cs_n)
      next_state.rises = 5'h00;
    else if (sck && !state.sck_q)
      next_state.rises = state.rises + 5'h01;
  end

  // Register the counter state
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= '0;
    else
      state <= next_state;
  end

  // ****************************************
  // Wire properties
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Lead time plus first low half of the clock
  sequence lead_s;
    !sck [*6];
  endsequence
  // One high half of the serial clock
  sequence high_phase_s;
    sck [*4] ##1 !sck;
  endsequence

  idle_clock_low_a : assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  select_lead_a : assert property ($fell(cs_n) |-> lead_s)
    else $error("serial clock rose too soon after select");
  clock_high_a : assert property ($rose(sck) |-> high_phase_s)
    else $error("serial clock high phase has wrong length");
  sdi_hold_a : assert property (sck && $past(sck) |-> $stable(sdi))
    else $error("data input moved while clock high");
  frame_bits_a : assert property ($rose(cs_n) |-> state.rises == 5'h18)
    else $error("frame did not hold 24 clock rises");
  select_lag_a : assert property ($fell(sck) && state.rises == 5'h18 |-> !cs_n [*3])
    else $error("select rose before the lag time");
  no_early_drive_a : assert property (!cs_n && state.rises < 5'h10 |-> sdo_oe_n)
    else $error("device drove output before the data byte");
  open_drain_a : assert property (!sdo_oe_n |-> !sdo_drive && !sdo_line)
    else $error("driven output is not low");
  deselect_release_a : assert property (cs_n [*5] |-> sdo_oe_n)
    else $error("output not released while deselected");
  sdo_hold_a : assert property (!cs_n && state.rises > 5'h10 && sck && $past(sck) |-> $stable(sdo_oe_n))
    else $error("output changed while clock high");
endmodule : pot_spi_monitor

// ==== tb_top.sv ====
// Bench joining host end and device end over the serial link
`timescale 1ns/100ps
module tb_top;
  import pot_spi_pkg::*;
  localparam int NVW = 800; // Long enough to overlap the next two frames
  logic clk_i, reset_n_i, shutdown_n_i, wr_i, rd_i;
  logic [1:0] addr_i;
  logic [7:0] wdata_i, rdata_o, rx;
  logic [6:0] wiper0_tap_o, wiper1_tap_o;
  logic high_open_o, nv_write_pending_o;
  int error_cnt, check_count, vsel, shd, nvb; // Model control bits and pending flag
  int nv[0:6]; // Model stored values, reset 00h
  int wiper[0:1]; // Model wipers
  spi_link_if link();
  pot_spi_host i_pot_spi_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  pot_spi_device #(.NV_WRITE_CYCLES(NVW)) i_pot_spi_device (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .link(link), .shutdown_n_i(shutdown_n_i), .wiper0_tap_o(wiper0_tap_o), .wiper1_tap_o(wiper1_tap_o),
    .high_open_o(high_open_o), .nv_write_pending_o(nv_write_pending_o));
  pot_spi_monitor i_pot_spi_monitor (.clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n(link.cs_n), .sck(link.sck),
    .sdi(link.sdi), .sdo_drive(link.sdo_drive), .sdo_oe_n(link.sdo_oe_n), .sdo_line(link.sdo_line));

  // ****************************************
  // Clock, checks and model
  // ****************************************
  // 10 MHz system clock
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_flag(string what, logic exp, logic got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s: expected %b, seen %b", what, exp, got);
    end
  endtask : check_flag

  // Writes to pots and control are refused while a stored write runs
  function automatic void mdl_wr(int a, int v);
    if (a <= 1 && nvb == 0)
    begin
      wiper[a] = v;
      if (vsel == 0)
      begin
        nv[a] = v;
        nvb = 1;
      end
    end
    else if (a >= 2 && a <= 6)
    begin
      nv[a] = v;
      nvb = 1;
    end
    else if (a == 8 && nvb == 0)
    begin
      vsel = v[7];
      shd = v[6];
    end
  endfunction : mdl_wr

  // Expected read data; reserved places read zero
  function automatic logic [7:0] mdl_rd(int a);
    if (a <= 1)
      return 8'(vsel != 0 ? wiper[a] : nv[a]);
    if (a <= 6)
      return 8'(nv[a]);
    if (a == 8)
      return {vsel[0], shd[0], nvb[0], 5'h00};
    return 8'h00;
  endfunction : mdl_rd

  // ****************************************
  // Register port and frame tasks
  // ****************************************
  task automatic bus_wr(logic [1:0] a, logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : bus_wr

  // Read data stands only in the cycle after the strobe
  task automatic bus_rd(logic [1:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : bus_rd

  // One whole frame; busy polled under a bound
  task automatic frame(logic rd, logic [3:0] a, logic [7:0] v);
    logic [7:0] s;
    int n;
    bus_wr(HOST_TXDATA, v);
    bus_wr(HOST_CMD, {1'b1, 2'b00, rd, a});
    s = 8'h01;
    for (n = 0; n < 400 && s[0] !== 1'b0; n++)
      bus_rd(HOST_STATUS, s);
    if (s[0] !== 1'b0)
    begin
      error_cnt++;
      summarize();
    end
    bus_rd(HOST_RXDATA, rx);
    if (!rd)
      mdl_wr(a, v);
  endtask : frame

  task automatic rd_chk(logic [3:0] a);
    frame(1'b1, a, 8'h00);
    check_byte("read data", mdl_rd(a), rx);
  endtask : rd_chk

  // Taps read zero and high end opens in shutdown
  task automatic chk_taps();
    logic off;
    off = shd[0] | !shutdown_n_i;
    check_flag("high_open", off, high_open_o);
    check_byte("tap0", off ? 8'h00 : 8'(wiper[0] & 8'h7f), {1'b0, wiper0_tap_o});
    check_byte("tap1", off ? 8'h00 : 8'(wiper[1] & 8'h7f), {1'b0, wiper1_tap_o});
  endtask : chk_taps

  // Pending must be up now and drop under a bound
  task automatic wait_nv();
    int n;
    check_flag("pending", 1'b1, nv_write_pending_o);
    for (n = 0; n < 2000 && nv_write_pending_o !== 1'b0; n++)
      @(posedge clk_i) #1;
    check_flag("pending end", 1'b0, nv_write_pending_o);
    nvb = 0;
    if (nv_write_pending_o !== 1'b0)
      summarize();
  endtask : wait_nv

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    reset_n_i = 1'b0;
    shutdown_n_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 2'h0;
    wdata_i = 8'h00;
    void'($urandom(32'h4d59));
    @(posedge clk_i);
    #1 check_byte("reset tap", 8'h40, {1'b0, wiper0_tap_o});
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    #1 chk_taps();
    $display("Test boot done");
    // Wiper-only access
    frame(1'b0, ADDR_ACCESS_CONTROL, 8'h80);
    rd_chk(ADDR_ACCESS_CONTROL);
    for (int p = 0; p < 2; p++)
    begin
      frame(1'b0, 4'(p), 8'($urandom_range(127)));
      chk_taps();
      rd_chk(4'(p));
    end
    frame(1'b0, ADDR_ACCESS_CONTROL, 8'h00);
    rd_chk(ADDR_POT0);
    $display("Test volatile done");
    // Stored write, then refused writes while pending
    frame(1'b0, ADDR_POT0, 8'($urandom_range(127)));
    rd_chk(ADDR_ACCESS_CONTROL);
    frame(1'b0, ADDR_POT1, 8'h7f);
    wait_nv();
    chk_taps();
    rd_chk(ADDR_ACCESS_CONTROL);
    rd_chk(ADDR_POT0);
    rd_chk(ADDR_POT1);
    frame(1'b0, 4'h2, 8'($urandom));
    frame(1'b0, ADDR_ACCESS_CONTROL, 8'h80);
    rd_chk(ADDR_ACCESS_CONTROL);
    wait_nv();
    $display("Test stored done");
    // Spare stored places, one per frame
    for (int a = 2; a <= 6; a++)
    begin
      frame(1'b0, 4'(a), 8'($urandom));
      wait_nv();
      rd_chk(4'(a));
    end
    rd_chk(4'h7);
    rd_chk(4'h9);
    $display("Test spare done");
    // Shutdown by pin, then by control bit
    @(posedge clk_i);
    shutdown_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1 chk_taps();
    rd_chk(ADDR_POT0);
    @(posedge clk_i);
    shutdown_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1 chk_taps();
    frame(1'b0, ADDR_ACCESS_CONTROL, 8'hc0);
    chk_taps();
    frame(1'b0, ADDR_POT1, 8'h2a);
    frame(1'b0, ADDR_ACCESS_CONTROL, 8'h80);
    chk_taps();
    $display("Test shutdown done");
    summarize();
  end
endmodule : tb_top
